/* src/lpc_regs.sv */
// Low-power entry control registers and wait-for-event sequencing.
//
// The implementer's own choices: the strobed register port and the register offsets.
`default_nettype none
// Contract
// - With wake_on_pend clear, only enabled interrupts or events wake a waiting core.
// - With wake_on_pend set, any newly pending interrupt also wakes the waiting core.
// - An eligible event or pending interrupt raises the event signal ending a wait.
// - An event while running outside a wait is latched; next wait completes at once and clears it.
// - Send-event instruction or external event input also wakes a waiting core.
// - deep_sleep_select picks sleep (0) or deep sleep (1) on sleep entry.
// - sleep_on_isr_return set makes return to thread mode enter low power.
// - branch_predict_indicator always reads one; writes do nothing.
// - icache_enable is read-write; one enables the instruction cache.

module lpc_regs
  import lpc_pkg::*;
#(
  parameter int N_IRQ = 32
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Core execution events, one-cycle pulses.
  input wire logic wait_event_instruction,
  input wire logic send_event_instruction,
  input wire logic ext_event_in,
  input wire logic exc_return_to_thread,
  // Interrupt controller view.
  input wire logic [N_IRQ-1:0] irq_pend_rise,
  input wire logic [N_IRQ-1:0] irq_enable,
  // Power controller and core outputs.
  output logic core_sleeping,
  output logic sleep_mode_deep,
  output logic core_wake,
  output logic icache_enable,
  output logic wake_on_pend,
  output logic sleep_on_isr_return
);

  // ==========================================================
  // Parameter check.
  if (N_IRQ < 1 || N_IRQ > 496) begin : g_bad_irq
    $error("N_IRQ must lie between 1 and 496");
  end

  lpc_regs_t cur_reg;
  lpc_regs_t cur_next;

  // ==========================================================
  // Interrupt eligibility per line.
  logic [N_IRQ-1:0] irq_elig;
  logic [N_IRQ-1:0] irq_en_pend;

  for (genvar i = 0; i < N_IRQ; i++) begin : g_irq
    // Disabled lines count only while wake_on_pend is set.
    assign irq_elig[i] = irq_pend_rise[i]
      & (irq_enable[i] | cur_reg.wake_on_pend);
    assign irq_en_pend[i] = irq_pend_rise[i] & irq_enable[i];
  end

  logic any_event;
  logic en_irq_event;

  assign en_irq_event = |irq_en_pend;
  // Internal event signal.
  assign any_event = (|irq_elig) | send_event_instruction
    | ext_event_in;

  logic wr_ctrl;
  logic wr_cfg;

  assign wr_ctrl = reg_wr && (reg_addr == LPC_LP_CTRL_OFS);
  assign wr_cfg = reg_wr && (reg_addr == LPC_CORE_CFG_OFS);

  // ==========================================================
  // Read data views.
  logic [31:0] ctrl_view;
  logic [31:0] cfg_view;

  always_comb begin
    // Unlisted bits stay zero.
    ctrl_view = 32'h0000_0000;
    ctrl_view[LPC_WAKE_PEND_BIT] = cur_reg.wake_on_pend;
    ctrl_view[LPC_DEEP_SEL_BIT] = cur_reg.deep_sleep_select;
    ctrl_view[LPC_RET_SLEEP_BIT] = cur_reg.sleep_on_isr_return;
    cfg_view = 32'h0000_0000;
    cfg_view[LPC_PRED_IND_BIT] = LPC_PRED_IND_VAL;
    cfg_view[LPC_ICACHE_BIT] = cur_reg.icache_enable;
  end

  // ==========================================================
  // Next state.
  always_comb begin
    cur_next = cur_reg;
    cur_next.wake_pulse = 1'b0;
    cur_next.rd_data = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        LPC_LP_CTRL_OFS: cur_next.rd_data = ctrl_view;
        LPC_CORE_CFG_OFS: cur_next.rd_data = cfg_view;
        default: cur_next.rd_data = 32'h0000_0000;
      endcase
    end
    if (wr_ctrl) begin
      cur_next.wake_on_pend = reg_wdata[LPC_WAKE_PEND_BIT];
      cur_next.deep_sleep_select = reg_wdata[LPC_DEEP_SEL_BIT];
      cur_next.sleep_on_isr_return = reg_wdata[LPC_RET_SLEEP_BIT];
    end
    if (wr_cfg) begin
      // The indicator bit is a constant, so only the cache enable takes data.
      cur_next.icache_enable = reg_wdata[LPC_ICACHE_BIT];
    end
    case (cur_reg.st)
      LPC_RUN: begin
        if (wait_event_instruction) begin
          if (cur_reg.event_latch || any_event) begin
            // A pending event lets the wait complete at once and is consumed.
            cur_next.event_latch = 1'b0;
            cur_next.wake_pulse = 1'b1;
          end else begin
            cur_next.st = LPC_WAIT_EVT;
          end
        end else begin
          // A handler return beside a wait instruction is dropped: the wait wins.
          if (any_event) begin
            cur_next.event_latch = 1'b1;
          end
          if (exc_return_to_thread && cur_reg.sleep_on_isr_return) begin
            cur_next.st = LPC_RET_SLEEP;
          end
        end
      end
      LPC_WAIT_EVT: begin
        if (any_event) begin
          cur_next.st = LPC_RUN;
          cur_next.wake_pulse = 1'b1;
        end
      end
      LPC_RET_SLEEP: begin
        // Sleep taken on handler return ends on an enabled interrupt
        // or an event; a disabled line cannot reach a handler.
        if (en_irq_event || send_event_instruction || ext_event_in) begin
          cur_next.st = LPC_RUN;
          cur_next.wake_pulse = 1'b1;
        end
      end
      default: begin
        cur_next.st = LPC_RUN;
      end
    endcase
  end

  // ==========================================================
  // State register.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cur_reg.st <= LPC_RUN;
      cur_reg.wake_on_pend <= LPC_WAKE_PEND_RST;
      cur_reg.deep_sleep_select <= LPC_DEEP_SEL_RST;
      cur_reg.sleep_on_isr_return <= LPC_RET_SLEEP_RST;
      cur_reg.icache_enable <= LPC_ICACHE_RST;
      cur_reg.event_latch <= 1'b0;
      cur_reg.wake_pulse <= 1'b0;
      cur_reg.rd_data <= 32'h0000_0000;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ==========================================================
  // Outputs.
  assign reg_rdata = cur_reg.rd_data;
  assign core_sleeping = (cur_reg.st != LPC_RUN);
  // The mode travels with the sleep request so the power controller
  // never sees a deep request while the core runs.
  assign sleep_mode_deep = core_sleeping
    & cur_reg.deep_sleep_select;
  assign core_wake = cur_reg.wake_pulse;
  assign icache_enable = cur_reg.icache_enable;
  assign wake_on_pend = cur_reg.wake_on_pend;
  assign sleep_on_isr_return = cur_reg.sleep_on_isr_return;

  // ==========================================================
  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_disabled_no_wake: assert property (
    (cur_reg.st == LPC_WAIT_EVT) && !cur_reg.wake_on_pend
    && !send_event_instruction && !ext_event_in
    && ((irq_pend_rise & irq_enable) == '0)
    |=> core_sleeping)
    else $error("disabled interrupt woke the core");

  a_pend_any_wake: assert property (
    (cur_reg.st == LPC_WAIT_EVT) && cur_reg.wake_on_pend
    && (|irq_pend_rise)
    |=> !core_sleeping && core_wake)
    else $error("pending interrupt did not wake the core");

  a_event_ends_wait: assert property (
    (cur_reg.st == LPC_WAIT_EVT) && any_event
    |=> (cur_reg.st == LPC_RUN) && core_wake)
    else $error("event did not end the wait");

  a_latch_set: assert property (
    (cur_reg.st == LPC_RUN) && !wait_event_instruction && any_event
    |=> cur_reg.event_latch)
    else $error("event outside a wait was not latched");

  a_latch_completes: assert property (
    (cur_reg.st == LPC_RUN) && !wait_event_instruction && any_event
    ##1 (cur_reg.st == LPC_RUN) && wait_event_instruction
    |=> !core_sleeping && !cur_reg.event_latch && core_wake)
    else $error("latched event did not complete the wait");

  a_event_with_wait: assert property (
    (cur_reg.st == LPC_RUN) && wait_event_instruction && any_event
    |=> !core_sleeping && core_wake)
    else $error("event beside the wait instruction did not complete it");

  a_wait_sleeps: assert property (
    (cur_reg.st == LPC_RUN) && wait_event_instruction
    && !cur_reg.event_latch && !any_event
    |=> core_sleeping && !core_wake)
    else $error("wait with no event did not sleep");

  a_wake_in_run: assert property (
    core_wake |-> !core_sleeping)
    else $error("wake pulse while the core sleeps");

  a_send_wakes: assert property (
    core_sleeping && (send_event_instruction || ext_event_in)
    |=> !core_sleeping)
    else $error("send event or external event did not wake");

  a_deep_mode: assert property (
    core_sleeping |-> (sleep_mode_deep == cur_reg.deep_sleep_select))
    else $error("sleep mode does not match deep select");

  a_deep_idle: assert property (
    !core_sleeping |-> !sleep_mode_deep)
    else $error("deep sleep signalled while the core runs");

  a_ctrl_write: assert property (
    wr_ctrl |=> (cur_reg.deep_sleep_select == $past(reg_wdata[LPC_DEEP_SEL_BIT]))
    && (sleep_on_isr_return == $past(reg_wdata[LPC_RET_SLEEP_BIT]))
    && (wake_on_pend == $past(reg_wdata[LPC_WAKE_PEND_BIT])))
    else $error("control write did not take the mode bits");

  a_ctrl_hold: assert property (
    !wr_ctrl |=> $stable(cur_reg.deep_sleep_select) && $stable(sleep_on_isr_return)
    && $stable(wake_on_pend))
    else $error("control bits changed without a write");

  a_return_sleep: assert property (
    (cur_reg.st == LPC_RUN) && exc_return_to_thread
    && !wait_event_instruction
    |=> core_sleeping == $past(cur_reg.sleep_on_isr_return))
    else $error("sleep on handler return is wrong");

  a_return_hold: assert property (
    (cur_reg.st == LPC_RET_SLEEP) && ((irq_pend_rise & irq_enable) == '0)
    && !send_event_instruction && !ext_event_in
    |=> core_sleeping)
    else $error("sleep after handler return ended without a wake source");

  // ==========================================================
  // Checks on the register port.
  a_pred_reads_one: assert property (
    reg_rd && (reg_addr == LPC_CORE_CFG_OFS)
    |=> reg_rdata[LPC_PRED_IND_BIT])
    else $error("branch predict indicator did not read one");

  a_icache_write: assert property (
    wr_cfg |=> icache_enable == $past(reg_wdata[LPC_ICACHE_BIT]))
    else $error("icache enable did not take written value");

  a_icache_hold: assert property (
    !wr_cfg |=> $stable(icache_enable))
    else $error("icache enable changed without a write");

  a_reserved_zero: assert property (
    reg_rd && (reg_addr == LPC_LP_CTRL_OFS)
    |=> (reg_rdata & ~32'h0000_0016) == 32'h0000_0000)
    else $error("reserved control bits read nonzero");

  a_cfg_reserved_zero: assert property (
    reg_rd && (reg_addr == LPC_CORE_CFG_OFS)
    |=> (reg_rdata & ~32'h0006_0000) == 32'h0000_0000)
    else $error("reserved configuration bits read nonzero");

  a_unmapped_zero: assert property (
    reg_rd && (reg_addr != LPC_LP_CTRL_OFS) && (reg_addr != LPC_CORE_CFG_OFS)
    |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped address read nonzero");

endmodule

`default_nettype wire

/* src/lpc_pkg.sv */
// Package for the low-power entry control register block.
`default_nettype none

package lpc_pkg;

  // ==========================================================
  // Register map (byte offsets).
  localparam logic [7:0] LPC_LP_CTRL_OFS = 8'h00;
  localparam logic [7:0] LPC_CORE_CFG_OFS = 8'h04;

  // ==========================================================
  // Field positions.
  localparam int LPC_WAKE_PEND_BIT = 4;
  localparam int LPC_DEEP_SEL_BIT = 2;
  localparam int LPC_RET_SLEEP_BIT = 1;
  localparam int LPC_PRED_IND_BIT = 18;
  localparam int LPC_ICACHE_BIT = 17;

  // ==========================================================
  // Reset values.
  localparam logic LPC_WAKE_PEND_RST = 1'b0;
  localparam logic LPC_DEEP_SEL_RST = 1'b0;
  localparam logic LPC_RET_SLEEP_RST = 1'b0;
  localparam logic LPC_ICACHE_RST = 1'b0;
  localparam logic LPC_PRED_IND_VAL = 1'b1;

  // ==========================================================
  // Core power state.
  typedef enum logic [1:0] {
    LPC_RUN,
    LPC_WAIT_EVT,
    LPC_RET_SLEEP
  } lpc_state_t;

  typedef struct packed {
    lpc_state_t st;
    logic wake_on_pend;
    logic deep_sleep_select;
    logic sleep_on_isr_return;
    logic icache_enable;
    logic event_latch;
    logic wake_pulse;
    logic [31:0] rd_data;
  } lpc_regs_t;

endpackage

`default_nettype wire

/* test/lpc_regs_test.sv */
// Self-checking bench for the low-power entry control registers.
`default_nettype none

module lpc_regs_test
  import lpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Stimulus and observation signals.
  localparam logic [3:0] C_WAIT = 4'h8;
  localparam logic [3:0] C_SEND = 4'h4;
  localparam logic [3:0] C_EXT = 4'h2;
  localparam logic [3:0] C_EXR = 4'h1;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic wait_event_instruction = 1'b0;
  logic send_event_instruction = 1'b0;
  logic ext_event_in = 1'b0;
  logic exc_return_to_thread = 1'b0;
  logic [31:0] irq_pend_rise = 32'h0000_0000;
  logic [31:0] irq_enable = 32'h0000_0000;
  logic core_sleeping, sleep_mode_deep, core_wake, icache_enable, wake_on_pend, sleep_on_isr_return;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000_e3ee;
  logic [37:0] exp_q[$];
  logic [37:0] got, e;
  logic wp = 1'b0, ds = 1'b0, so = 1'b0, icen = 1'b0;
  logic [31:0] r;

  lpc_regs i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wait_event_instruction(wait_event_instruction),
    .send_event_instruction(send_event_instruction), .ext_event_in(ext_event_in),
    .exc_return_to_thread(exc_return_to_thread), .irq_pend_rise(irq_pend_rise), .irq_enable(irq_enable),
    .core_sleeping(core_sleeping), .sleep_mode_deep(sleep_mode_deep), .core_wake(core_wake),
    .icache_enable(icache_enable), .wake_on_pend(wake_on_pend), .sleep_on_isr_return(sleep_on_isr_return));

  always #5 clk_sys = ~clk_sys;

  // ==========================================================
  // Closing report and hang guard.
  task automatic end_sim();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end

  // Outputs are settled by the falling edge, so the oldest note is compared there.
  always @(negedge clk_sys) begin
    if (exp_q.size() > 0) begin
      got = {core_sleeping, sleep_mode_deep, core_wake, icache_enable, wake_on_pend, sleep_on_isr_return, reg_rdata};
      e = exp_q.pop_front();
      cmp_count++;
      if (got !== e) begin
        error_cnt++;
        $display("[ERR] %0t outputs %h expected %h", $time, got, e);
      end
    end
  end

  // ==========================================================
  // Drivers.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Every input is assigned once per edge, so no pulse is cleared and raised in one time step.
  task automatic op(input logic [3:0] ctl, input logic [1:0] wr_rd, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] pend, input logic slp, input logic wk, input logic [31:0] rd);
    {wait_event_instruction, send_event_instruction, ext_event_in, exc_return_to_thread} <= ctl;
    {reg_wr, reg_rd} <= wr_rd;
    reg_addr <= a;
    reg_wdata <= d;
    irq_pend_rise <= pend;
    @(posedge clk_sys);
    if (wr_rd[1] && a == LPC_LP_CTRL_OFS) begin
      {wp, ds, so} = {d[LPC_WAKE_PEND_BIT], d[LPC_DEEP_SEL_BIT], d[LPC_RET_SLEEP_BIT]};
    end
    if (wr_rd[1] && a == LPC_CORE_CFG_OFS) begin
      icen = d[LPC_ICACHE_BIT];
    end
    exp_q.push_back({slp, slp & ds, wk, icen, wp, so, rd});
  endtask

  task automatic ev(input logic [3:0] ctl, input logic [31:0] pend, input logic slp, input logic wk);
    op(ctl, 2'b00, 8'h00, '0, pend, slp, wk, '0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    op(4'h0, 2'b10, a, d, '0, 1'b0, 1'b0, '0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    op(4'h0, 2'b01, a, '0, '0, 1'b0, 1'b0, x);
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    // Line 0 stays disabled and line 1 enabled; the rest are random.
    irq_enable <= (rnd() | 32'h0000_0002) & 32'hffff_fffe;
    rd(LPC_LP_CTRL_OFS, 32'h0000_0000);
    rd(LPC_CORE_CFG_OFS, 32'h0004_0000);
    rd(8'h08, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      wr(LPC_LP_CTRL_OFS, r);
      rd(LPC_LP_CTRL_OFS, r & 32'h0000_0016);
      r = rnd();
      wr(LPC_CORE_CFG_OFS, r);
      rd(LPC_CORE_CFG_OFS, (r & 32'h0002_0000) | 32'h0004_0000);
      wr(8'h0c, rnd());
      rd(8'h0c, 32'h0000_0000);
    end
    wr(LPC_LP_CTRL_OFS, 32'h0000_0000);
    ev(C_WAIT, '0, 1'b1, 1'b0);
    ev(4'h0, 32'h0000_0001, 1'b1, 1'b0);
    ev(4'h0, 32'h0000_0002, 1'b0, 1'b1);
    ev(4'h0, '0, 1'b0, 1'b0);
    wr(LPC_LP_CTRL_OFS, 32'h0000_0014);
    ev(C_WAIT, '0, 1'b1, 1'b0);
    ev(4'h0, 32'h0000_0001, 1'b0, 1'b1);
    ev(C_SEND, '0, 1'b0, 1'b0);
    ev(C_WAIT, '0, 1'b0, 1'b1);
    ev(C_WAIT, '0, 1'b1, 1'b0);
    ev(C_EXT, '0, 1'b0, 1'b1);
    ev(C_WAIT, '0, 1'b1, 1'b0);
    ev(C_SEND, '0, 1'b0, 1'b1);
    wr(LPC_LP_CTRL_OFS, 32'h0000_0002);
    ev(C_EXR, '0, 1'b1, 1'b0);
    ev(4'h0, 32'h0000_0001, 1'b1, 1'b0);
    ev(4'h0, 32'h0000_0002, 1'b0, 1'b1);
    wr(LPC_LP_CTRL_OFS, 32'h0000_0000);
    ev(C_EXR, '0, 1'b0, 1'b0);
    ev(4'h0, '0, 1'b0, 1'b0);
    // An event beside the wait completes it; an enabled line in run is latched.
    ev(C_WAIT | C_EXT, '0, 1'b0, 1'b1);
    ev(4'h0, 32'h0000_0002, 1'b0, 1'b0);
    ev(C_WAIT, '0, 1'b0, 1'b1);
    wr(LPC_LP_CTRL_OFS, 32'h0000_0006);
    ev(C_EXR, '0, 1'b1, 1'b0);
    ev(C_SEND, '0, 1'b0, 1'b1);
    ev(4'h0, '0, 1'b0, 1'b0);
    @(posedge clk_sys);
    end_sim();
  end

endmodule

`default_nettype wire
